// [src/spx_pkg.sv]
// Package of constants for the stack pointer extended instruction block
package spx_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PTR_W = 12;
  localparam int PC_W = 21;
  localparam int BSR_W = 4;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 16;
  // ----------------------------------------------------------------
  // Opcode fields and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_PUSH_LITERAL = 8'hFA;
  localparam logic [7:0] OPC_PTR_SUBTRACT = 8'hE9;
  localparam logic [7:0] OPC_PTR_ADD = 8'hE8;
  localparam logic [7:0] OPC_MOVE_INDEXED = 8'hEB;
  localparam logic [15:0] OPC_CALL_W = 16'h0014;
  localparam int SEL_POS = 6;
  localparam int ACCESS_POS = 8;
  localparam logic [1:0] SEL_RETURN = 2'h3;
  localparam logic [1:0] SEL_STACK = 2'h2;
  localparam logic [1:0] SEL_PTR1 = 2'h1;
  localparam logic [1:0] SEL_PTR0 = 2'h0;
  // ----------------------------------------------------------------
  // Addressing constants
  // ----------------------------------------------------------------
  localparam logic [7:0] OFFSET_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  // ----------------------------------------------------------------
  // Reset values and cycle counts
  // ----------------------------------------------------------------
  localparam logic [11:0] RST_PTR = 12'h000;
  localparam logic [20:0] RST_PC = 21'h000000;
  localparam logic RST_EXT_ENABLE = 1'b0;
  localparam int RETURN_CYCLES = 2;
  // ----------------------------------------------------------------
  // Execution states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_NOP = 2'b10
  } spx_state_t;
endpackage : spx_pkg

// [src/spx_addr_resolve.sv]
// Operand address resolution for access-bit instructions
`timescale 1ns/1ps
module spx_addr_resolve
  import spx_pkg::*;
(
  input wire logic [7:0] file_arg,
  input wire logic access_bit,
  input wire logic ext_enable,
  input wire logic [spx_pkg::PTR_W-1:0] stack_ptr,
  input wire logic [spx_pkg::BSR_W-1:0] bank_sel,
  output logic [spx_pkg::PTR_W-1:0] addr
);
  // ----------------------------------------------------------------
  // Address mux
  // ----------------------------------------------------------------
  // Low arguments index off the stack pointer only in extended mode; with
  // the pointer at zero this lands on the same low access bank cells
  always_comb
  begin
    if (ext_enable && !access_bit && (file_arg <= OFFSET_LIMIT))
      addr = stack_ptr + {4'h0, file_arg}; // [RULE_08] [RULE_11]
    else if (!access_bit && (file_arg <= OFFSET_LIMIT))
      addr = {ACCESS_LOW_BANK, file_arg}; // [RULE_07]
    else if (!access_bit)
      addr = {ACCESS_HIGH_BANK, file_arg}; // [RULE_07]
    else
      addr = {bank_sel, file_arg}; // [RULE_07]
  end
endmodule : spx_addr_resolve

// [src/spx_core.sv]
// Executes pointer push and subtract ops and resolves indexed operands
// Overview of operation
// RULE_01: Push stores literal at stack pointer address
// RULE_02: Push then decrements stack pointer, one cycle
// RULE_03: Pointer subtract takes literal from selected pointer
// RULE_04: Subtract-return adjusts stack pointer, loads return address
// RULE_05: Subtract-return spends second cycle doing nothing
// RULE_06: Selector three means subtract-return on stack pointer
// RULE_07: Disabled mode uses file address literally
// RULE_08: Enabled, low unbanked argument offsets stack pointer
// RULE_09: Offsetting covers all access-bit instructions
// RULE_10: One enable gates new opcodes and offsetting
// RULE_11: Zero stack pointer reproduces plain access mapping
// RULE_12: Enable configuration bit defaults to zero
// RULE_13: Pointer arithmetic wraps, visible to next instruction
`timescale 1ns/1ps
module spx_core
  import spx_pkg::*;
#(
  parameter int PTR_W = spx_pkg::PTR_W,
  parameter int PC_W = spx_pkg::PC_W
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [spx_pkg::INSTR_W-1:0] instr,
  input wire logic extended_set_enable,
  input wire logic [spx_pkg::BSR_W-1:0] bank_select_reg,
  input wire logic [PC_W-1:0] return_stack_top,
  output logic [PTR_W-1:0] ptr0,
  output logic [PTR_W-1:0] ptr1,
  output logic [PTR_W-1:0] stack_pointer_reg,
  output logic mem_we,
  output logic [PTR_W-1:0] mem_addr,
  output logic [spx_pkg::DATA_W-1:0] mem_wdata,
  output logic operand_valid,
  output logic [PTR_W-1:0] operand_addr,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  output logic stall,
  output logic illegal_op,
  output logic ext_active
);
  import spx_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Any opcode of the extended group, valid only when the set is on
  function automatic logic is_ext_op(input logic [15:0] op);
    is_ext_op = (op[15:8] == OPC_PUSH_LITERAL) || (op[15:8] == OPC_PTR_SUBTRACT) ||
                (op[15:8] == OPC_PTR_ADD) || (op[15:8] == OPC_MOVE_INDEXED) ||
                (op == OPC_CALL_W);
  endfunction : is_ext_op

  // Byte and bit oriented ops carry the access bit at bit 8
  function automatic logic has_access_bit(input logic [15:0] op);
    has_access_bit = ((op[15:12] >= 4'h1) && (op[15:12] <= 4'hB)) ||
                     (op[15:9] == 7'h01) || (op[15:10] == 6'h01);
  endfunction : has_access_bit

  spx_state_t state;
  spx_state_t next_state;
  logic accept;
  logic [PTR_W-1:0] resolved_addr;
  logic [PTR_W-1:0] next_ptr0;
  logic [PTR_W-1:0] next_ptr1;
  logic [PTR_W-1:0] next_sp;
  logic next_mem_we;
  logic [PTR_W-1:0] next_mem_addr;
  logic [DATA_W-1:0] next_mem_wdata;
  logic next_operand_valid;
  logic [PTR_W-1:0] next_operand_addr;
  logic next_pc_load;
  logic [PC_W-1:0] next_pc_value;
  logic next_illegal;
  logic [PTR_W-1:0] lit6;

  // Second cycle of subtract-return refuses new instructions
  assign accept = instr_valid && (state == ST_RUN);
  assign lit6 = {{(PTR_W-6){1'b0}}, instr[5:0]};

  // ----------------------------------------------------------------
  // Operand address
  // ----------------------------------------------------------------
  spx_addr_resolve u_resolve (
    .file_arg(instr[7:0]),
    .access_bit(instr[ACCESS_POS]),
    .ext_enable(ext_active),
    .stack_ptr(stack_pointer_reg),
    .bank_sel(bank_select_reg),
    .addr(resolved_addr)
  );

  // ----------------------------------------------------------------
  // Configuration bit
  // ----------------------------------------------------------------
  // Follows the strap after reset; one enable drives both features
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ext_active <= RST_EXT_ENABLE; // [RULE_12]
    else
      ext_active <= extended_set_enable; // [RULE_10]
  end

  // ----------------------------------------------------------------
  // Execute next values
  // ----------------------------------------------------------------
  // All pointer math wraps at the pointer width by truncation
  always_comb
  begin
    next_state = ST_RUN;
    next_ptr0 = ptr0;
    next_ptr1 = ptr1;
    next_sp = stack_pointer_reg;
    next_mem_we = 1'b0;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_operand_valid = 1'b0;
    next_operand_addr = operand_addr;
    next_pc_load = 1'b0;
    next_pc_value = pc_value;
    next_illegal = 1'b0;
    if (accept)
    begin
      if (is_ext_op(instr) && !ext_active)
        next_illegal = 1'b1; // [RULE_10]
      else if (instr[15:8] == OPC_PUSH_LITERAL)
      begin
        next_mem_we = 1'b1; // [RULE_01]
        next_mem_addr = stack_pointer_reg; // [RULE_01]
        next_mem_wdata = instr[7:0]; // [RULE_01]
        next_sp = stack_pointer_reg - {{(PTR_W-1){1'b0}}, 1'b1}; // [RULE_02] [RULE_13]
      end
      else if (instr[15:8] == OPC_PTR_SUBTRACT)
      begin
        unique case (instr[7:SEL_POS])
          SEL_PTR0: next_ptr0 = ptr0 - lit6; // [RULE_03] [RULE_13]
          SEL_PTR1: next_ptr1 = ptr1 - lit6; // [RULE_03]
          SEL_STACK: next_sp = stack_pointer_reg - lit6; // [RULE_03]
          SEL_RETURN:
          begin
            next_sp = stack_pointer_reg - lit6; // [RULE_04] [RULE_06]
            next_pc_load = 1'b1; // [RULE_04]
            next_pc_value = return_stack_top; // [RULE_04]
            next_state = ST_NOP; // [RULE_05]
          end
        endcase
      end
      else if (has_access_bit(instr))
      begin
        next_operand_valid = 1'b1; // [RULE_09]
        next_operand_addr = resolved_addr; // [RULE_07] [RULE_08]
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= ST_RUN;
      ptr0 <= RST_PTR;
      ptr1 <= RST_PTR;
      stack_pointer_reg <= RST_PTR;
      mem_we <= 1'b0;
      mem_addr <= RST_PTR;
      mem_wdata <= 8'h00;
      operand_valid <= 1'b0;
      operand_addr <= RST_PTR;
      pc_load <= 1'b0;
      pc_value <= RST_PC;
      stall <= 1'b0;
      illegal_op <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ptr0 <= next_ptr0;
      ptr1 <= next_ptr1;
      stack_pointer_reg <= next_sp;
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      operand_valid <= next_operand_valid;
      operand_addr <= next_operand_addr;
      pc_load <= next_pc_load;
      pc_value <= next_pc_value;
      stall <= (next_state == ST_NOP); // [RULE_05]
      illegal_op <= next_illegal;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic go_push;
  logic go_sub;
  logic go_ret;
  logic go_low;
  assign go_push = accept && ext_active && (instr[15:8] == OPC_PUSH_LITERAL);
  assign go_sub = accept && ext_active && (instr[15:8] == OPC_PTR_SUBTRACT);
  assign go_ret = go_sub && (instr[7:SEL_POS] == SEL_RETURN);
  assign go_low = accept && has_access_bit(instr) && !instr[ACCESS_POS] &&
                  (instr[7:0] <= OFFSET_LIMIT);

  property p_push_store;
    @(posedge ref_clk) disable iff (rst)
    go_push |=> mem_we && (mem_addr == $past(stack_pointer_reg)) &&
                (mem_wdata == $past(instr[7:0]));
  endproperty
  a_push_store: assert property (p_push_store) else $error("push store wrong"); // [RULE_01]

  property p_push_dec;
    @(posedge ref_clk) disable iff (rst)
    go_push |=> (stack_pointer_reg == $past(stack_pointer_reg) - 12'h001) && !stall;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push decrement wrong"); // [RULE_02]

  property p_sub_ptr0;
    @(posedge ref_clk) disable iff (rst)
    go_sub && (instr[7:SEL_POS] == SEL_PTR0) |=>
      (ptr0 == $past(ptr0) - {6'h00, $past(instr[5:0])}) && (ptr1 == $past(ptr1));
  endproperty
  a_sub_ptr0: assert property (p_sub_ptr0) else $error("pointer subtract wrong"); // [RULE_03]

  property p_ret_pc;
    @(posedge ref_clk) disable iff (rst)
    go_ret |=> pc_load && (pc_value == $past(return_stack_top)) &&
               (stack_pointer_reg == $past(stack_pointer_reg) - {6'h00, $past(instr[5:0])});
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("subtract-return wrong"); // [RULE_04]

  property p_ret_two;
    @(posedge ref_clk) disable iff (rst)
    go_ret |=> stall ##1 (!stall && !pc_load && !mem_we && !operand_valid);
  endproperty
  a_ret_two: assert property (p_ret_two) else $error("return not two cycles"); // [RULE_05]

  property p_ret_sp_only;
    @(posedge ref_clk) disable iff (rst)
    go_ret |=> (ptr0 == $past(ptr0)) && (ptr1 == $past(ptr1));
  endproperty
  a_ret_sp_only: assert property (p_ret_sp_only) else $error("return touched other ptr"); // [RULE_06]

  property p_literal_addr;
    @(posedge ref_clk) disable iff (rst)
    go_low && !ext_active |=> operand_valid && (operand_addr == {4'h0, $past(instr[7:0])});
  endproperty
  a_literal_addr: assert property (p_literal_addr) else $error("literal address wrong"); // [RULE_07]

  property p_offset_addr;
    @(posedge ref_clk) disable iff (rst)
    go_low && ext_active |=>
      operand_valid && (operand_addr == $past(stack_pointer_reg) + {4'h0, $past(instr[7:0])});
  endproperty
  a_offset_addr: assert property (p_offset_addr) else $error("offset address wrong"); // [RULE_08]

  property p_disabled_ext;
    @(posedge ref_clk) disable iff (rst)
    accept && !ext_active && (instr[15:8] == OPC_PUSH_LITERAL) |=>
      illegal_op && !mem_we && $stable(stack_pointer_reg);
  endproperty
  a_disabled_ext: assert property (p_disabled_ext) else $error("disabled op executed"); // [RULE_10]

  c_push: cover property (@(posedge ref_clk) disable iff (rst) go_push);
  c_ret: cover property (@(posedge ref_clk) disable iff (rst) go_ret ##2 go_push);
  c_offset: cover property (@(posedge ref_clk) disable iff (rst) go_low && ext_active);
  c_illegal: cover property (@(posedge ref_clk) disable iff (rst) illegal_op);
endmodule : spx_core

// [tb/spx_core_bench.sv]
// Self-checking testbench for the stack pointer extended instruction core
`timescale 1ns/1ps
module spx_core_bench;
  import spx_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk;
  logic rst;
  logic instr_valid;
  logic [15:0] instr;
  logic extended_set_enable;
  logic [3:0] bank_select_reg;
  logic [20:0] return_stack_top;
  logic [11:0] ptr0, ptr1, stack_pointer_reg, mem_addr, operand_addr;
  logic [7:0] mem_wdata;
  logic [20:0] pc_value;
  logic mem_we, operand_valid, pc_load, stall, illegal_op, ext_active;
  int num_errors;
  int checks;
  logic [11:0] exp_sp;
  spx_core u_dut (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .extended_set_enable(extended_set_enable), .bank_select_reg(bank_select_reg),
    .return_stack_top(return_stack_top), .ptr0(ptr0), .ptr1(ptr1),
    .stack_pointer_reg(stack_pointer_reg), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .operand_valid(operand_valid), .operand_addr(operand_addr),
    .pc_load(pc_load), .pc_value(pc_value), .stall(stall), .illegal_op(illegal_op),
    .ext_active(ext_active));
  // ----------------------------------------------------------------
  // Clock, checking and closing helpers
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Case inequality so an unknown output never passes
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // One instruction presented for one edge; returns at the negedge where results stand.
  // Valid stays up so back-to-back calls never drive it twice in one time step;
  // the caller drops it before letting an idle edge pass.
  task automatic exec(input logic [15:0] op);
    instr = op;
    instr_valid = 1'b1;
    @(negedge ref_clk);
  endtask : exec
  task automatic access_op(input logic [15:0] op, input logic [11:0] exp);
    exec(op);
    chk("operand_valid", 32'h1, 32'(operand_valid));
    chk("operand_addr", 32'(exp), 32'(operand_addr));
  endtask : access_op
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Strap low out of reset: stack pointer clears and new opcodes are refused
  task automatic scen_disabled;
    chk("stack_pointer_reg", 32'h0, 32'(stack_pointer_reg));
    chk("ext_active", 32'h0, 32'(ext_active));
    exec({OPC_PUSH_LITERAL, 8'h11});
    chk("illegal_op", 32'h1, 32'(illegal_op));
    chk("mem_we", 32'h0, 32'(mem_we));
    exec({OPC_PTR_SUBTRACT, 8'hC5});
    chk("pc_load", 32'h0, 32'(pc_load));
    chk("stack_pointer_reg", 32'h0, 32'(stack_pointer_reg));
    // Low arguments stay literal even below the offset limit
    access_op(16'h2410, 12'h010);
    access_op(16'h24F0, 12'hFF0);
    access_op(16'h2510, 12'hA10);
    access_op(16'h8E05, 12'h005);
  endtask : scen_disabled
  // Zero pointer reproduces the plain access mapping
  task automatic scen_zero_sp;
    chk("ext_active", 32'h1, 32'(ext_active));
    access_op(16'h2420, 12'h020);
    access_op(16'h2400, 12'h000);
  endtask : scen_zero_sp
  // Largest literal on the pointer 0, pointer 1 and stack selectors, wrapping below zero
  task automatic scen_subtract;
    exec({OPC_PTR_SUBTRACT, SEL_PTR0, 6'h3F});
    chk("ptr0", 32'hFC1, 32'(ptr0));
    chk("ptr1", 32'h0, 32'(ptr1));
    exec({OPC_PTR_SUBTRACT, SEL_PTR1, 6'h3F});
    chk("ptr1", 32'hFC1, 32'(ptr1));
    chk("stack_pointer_reg", 32'h0, 32'(stack_pointer_reg));
    exec({OPC_PTR_SUBTRACT, SEL_STACK, 6'h3F});
    exp_sp = 12'hFC1;
    chk("stack_pointer_reg", 32'(exp_sp), 32'(stack_pointer_reg));
  endtask : scen_subtract
  // Back-to-back pushes: second one must see the decremented pointer
  task automatic scen_push;
    exec({OPC_PUSH_LITERAL, 8'h5A});
    chk("mem_we", 32'h1, 32'(mem_we));
    chk("mem_addr", 32'(exp_sp), 32'(mem_addr));
    chk("mem_wdata", 32'h5A, 32'(mem_wdata));
    chk("stack_pointer_reg", 32'(exp_sp - 12'h1), 32'(stack_pointer_reg));
    exec({OPC_PUSH_LITERAL, 8'hA5});
    chk("mem_addr", 32'(exp_sp - 12'h1), 32'(mem_addr));
    chk("mem_wdata", 32'hA5, 32'(mem_wdata));
    exp_sp = exp_sp - 12'h2;
    chk("stack_pointer_reg", 32'(exp_sp), 32'(stack_pointer_reg));
    instr_valid = 1'b0;
    @(negedge ref_clk);
    chk("mem_we", 32'h0, 32'(mem_we));
  endtask : scen_push
  // Subtract-return, then a push offered in the idle cycle must vanish
  task automatic scen_return;
    exec({OPC_PTR_SUBTRACT, SEL_RETURN, 6'h23});
    exp_sp = exp_sp - 12'h023;
    chk("stack_pointer_reg", 32'(exp_sp), 32'(stack_pointer_reg));
    chk("pc_load", 32'h1, 32'(pc_load));
    chk("pc_value", 32'h1ABCD5, 32'(pc_value));
    chk("stall", 32'h1, 32'(stall));
    chk("ptr0", 32'hFC1, 32'(ptr0));
    exec({OPC_PUSH_LITERAL, 8'h77});
    chk("stall", 32'h0, 32'(stall));
    chk("mem_we", 32'h0, 32'(mem_we));
    chk("pc_load", 32'h0, 32'(pc_load));
    chk("stack_pointer_reg", 32'(exp_sp), 32'(stack_pointer_reg));
  endtask : scen_return
  // Offset addressing on byte and bit ops, at and past the limit
  task automatic scen_offset;
    access_op(16'h245F, exp_sp + 12'h05F);
    access_op(16'h8E00, exp_sp);
    access_op(16'h2460, 12'hF60);
    access_op(16'h2510, 12'hA10);
  endtask : scen_offset
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    num_errors = 0;
    checks = 0;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = 16'h0000;
    extended_set_enable = 1'b0;
    bank_select_reg = 4'hA;
    return_stack_top = 21'h1ABCD5;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    scen_disabled();
    instr_valid = 1'b0;
    extended_set_enable = 1'b1;
    repeat (2) @(negedge ref_clk);
    scen_zero_sp();
    scen_subtract();
    scen_push();
    scen_return();
    scen_offset();
    wrap_up();
  end
  // Whole run is well under 100 cycles; allow a wide margin
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    num_errors++;
    wrap_up();
  end
endmodule : spx_core_bench
